// *** design/pcc_ctrl.sv ***
// pc card control sequencer: drives the 16-bit card strobes and selects
// assumes a host request port synchronous to ref_clk and card pins already synchronous
//
// Behaviour
// [R1] memory read drives output enable low so the card drives data
// [R2] dma write asserts output enable as terminal count
// [R3] memory card holds ready low while busy, high when it can accept
// [R4] shared ready input means ready only in memory-only configuration
// [R5] io card pulls interrupt request low when it needs service
// [R6] attribute select stays high for every common memory access
// [R7] attribute select with oe/we hits attribute memory, with io strobes io space
// [R8] dma asserts attribute select as acknowledge, data moves on io strobes
// [R9] card reset output forces a hard reset of the card
// [R10] operating voltage comes from both sense lines together
// [R11] card wait stretches the cycle; controller holds the strobe meanwhile
// [R12] write enable pulses write data into memory cards
// [R13] dma read asserts write enable as terminal count
// [R14] memory card shows its write-protect switch on write protect
// [R15] io card flags a 16-bit port on the shared write-protect input
// [R16] write protect may serve as dma request when so configured
// [R17] io read for card-to-memory dma, io write for memory-to-card dma
// [R18] first card enable selects even bytes, second selects odd bytes
// [R19] output enable and write enable never low in the same cycle
`timescale 1ns/100ps
`default_nettype none
`include "pcc_defs.svh"

module pcc_ctrl (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic req_valid,
	input wire pcc_pkg::pcc_req_t req,
	output logic req_ready,
	output logic req_done,
	input wire logic mem_only,
	input wire logic dma_req_en,
	input wire logic card_reset_req,
	input wire pcc_pkg::pcc_card_in_t card_in,
	output pcc_pkg::pcc_card_out_t card_out,
	output pcc_pkg::pcc_status_t status
);

	typedef struct packed {
		pcc_pkg::pcc_state_t st;
		logic [`PCC_CNT_W-1:0] cnt;
		pcc_pkg::pcc_req_t cur;
		logic ready;
		logic done;
		pcc_pkg::pcc_card_out_t pins;
	} pcc_ctrl_state_t;

	pcc_ctrl_state_t s_d;
	pcc_ctrl_state_t s_q;
	logic is_mem;
	logic is_rd_strobe;
	logic is_wr_strobe;
	logic is_ior_strobe;
	logic is_iow_strobe;

	// strobe choice per operation; decoded from the latched request
	always_comb begin
		is_mem = (s_q.cur.op == pcc_pkg::PCC_OP_MEM_RD) || (s_q.cur.op == pcc_pkg::PCC_OP_MEM_WR);
		is_rd_strobe = (s_q.cur.op == pcc_pkg::PCC_OP_MEM_RD) // [R1]
			|| (s_q.cur.op == pcc_pkg::PCC_OP_ATTR_RD)
			|| ((s_q.cur.op == pcc_pkg::PCC_OP_DMA_WR) && s_q.cur.last); // [R2]
		is_wr_strobe = (s_q.cur.op == pcc_pkg::PCC_OP_MEM_WR) // [R12]
			|| (s_q.cur.op == pcc_pkg::PCC_OP_ATTR_WR)
			|| ((s_q.cur.op == pcc_pkg::PCC_OP_DMA_RD) && s_q.cur.last); // [R13]
		is_ior_strobe = (s_q.cur.op == pcc_pkg::PCC_OP_IO_RD)
			|| (s_q.cur.op == pcc_pkg::PCC_OP_DMA_WR); // [R17]
		is_iow_strobe = (s_q.cur.op == pcc_pkg::PCC_OP_IO_WR)
			|| (s_q.cur.op == pcc_pkg::PCC_OP_DMA_RD); // [R17]
	end

	always_comb begin
		s_d = s_q;
		s_d.done = 1'h0;
		s_d.pins.card_reset = card_reset_req; // [R9]
		s_d.pins.vs_out = `PCC_VS_DRIVE;
		s_d.pins.vs_oe = `PCC_VS_DRIVE;
		case (s_q.st)
			pcc_pkg::PCC_ST_IDLE: begin
				// a card held in reset takes no cycles
				if (req_valid && s_q.ready && !card_reset_req) begin
					s_d.cur = req;
					s_d.st = pcc_pkg::PCC_ST_SETUP;
					s_d.cnt = `PCC_CNT_W'(`PCC_SETUP_CYC - 1);
					s_d.ready = 1'h0;
					// common memory keeps reg high; attr, io and dma pull it low
					s_d.pins.reg_n = ((req.op == pcc_pkg::PCC_OP_MEM_RD)
						|| (req.op == pcc_pkg::PCC_OP_MEM_WR))
						? `PCC_PIN_IDLE : `PCC_PIN_ACTIVE; // [R6] [R7] [R8]
					s_d.pins.card_enable_even_n = ~req.lane_even; // [R18]
					s_d.pins.card_enable_odd_n = ~req.lane_odd; // [R18]
				end else begin
					s_d.ready = !card_reset_req;
				end
			end
			pcc_pkg::PCC_ST_SETUP: begin
				if (s_q.cnt != '0) begin
					s_d.cnt = s_q.cnt - `PCC_CNT_W'(1);
				end else begin
					s_d.st = pcc_pkg::PCC_ST_STROBE;
					s_d.cnt = `PCC_CNT_W'(`PCC_STROBE_CYC - 1);
					// no op decodes both oe and we, so oe and we never meet
					s_d.pins.oe_n = ~is_rd_strobe; // [R1] [R2] [R19]
					s_d.pins.we_n = ~is_wr_strobe; // [R12] [R13] [R19]
					s_d.pins.io_read_n = ~is_ior_strobe; // [R8] [R17]
					s_d.pins.io_write_n = ~is_iow_strobe; // [R8] [R17]
				end
			end
			pcc_pkg::PCC_ST_STROBE: begin
				if (s_q.cnt != '0) begin
					s_d.cnt = s_q.cnt - `PCC_CNT_W'(1);
				end else if (card_in.wait_n) begin // [R11]
					s_d.st = pcc_pkg::PCC_ST_HOLD;
					s_d.cnt = `PCC_CNT_W'(`PCC_HOLD_CYC - 1);
					s_d.pins.oe_n = `PCC_PIN_IDLE;
					s_d.pins.we_n = `PCC_PIN_IDLE;
					s_d.pins.io_read_n = `PCC_PIN_IDLE;
					s_d.pins.io_write_n = `PCC_PIN_IDLE;
				end
			end
			pcc_pkg::PCC_ST_HOLD: begin
				if (s_q.cnt != '0) begin
					s_d.cnt = s_q.cnt - `PCC_CNT_W'(1);
				end else begin
					s_d.st = pcc_pkg::PCC_ST_IDLE;
					s_d.done = 1'h1;
					s_d.ready = !card_reset_req;
					s_d.pins.reg_n = `PCC_PIN_IDLE;
					s_d.pins.card_enable_even_n = `PCC_PIN_IDLE;
					s_d.pins.card_enable_odd_n = `PCC_PIN_IDLE;
				end
			end
			default: begin
				s_d.st = pcc_pkg::PCC_ST_IDLE;
				s_d.ready = 1'h0;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_q.st <= pcc_pkg::PCC_ST_IDLE;
			s_q.cnt <= '0;
			s_q.cur <= '0;
			s_q.ready <= 1'h0;
			s_q.done <= 1'h0;
			s_q.pins.oe_n <= `PCC_PIN_IDLE;
			s_q.pins.we_n <= `PCC_PIN_IDLE;
			s_q.pins.reg_n <= `PCC_PIN_IDLE;
			s_q.pins.io_read_n <= `PCC_PIN_IDLE;
			s_q.pins.io_write_n <= `PCC_PIN_IDLE;
			s_q.pins.card_enable_even_n <= `PCC_PIN_IDLE;
			s_q.pins.card_enable_odd_n <= `PCC_PIN_IDLE;
			s_q.pins.card_reset <= `PCC_CARD_RESET_INIT;
			s_q.pins.vs_out <= `PCC_VS_DRIVE;
			s_q.pins.vs_oe <= `PCC_VS_DRIVE;
		end else begin
			s_q <= s_d;
		end
	end

	assign req_ready = s_q.ready;
	assign req_done = s_q.done;
	assign card_out = s_q.pins;

	// status pins are decoded and registered in the sense stage
	pcc_sense u_sense (
		.ref_clk(ref_clk),
		.srst(srst),
		.card_in(card_in),
		.mem_only(mem_only),
		.dma_req_en(dma_req_en),
		.status(status)
	);

	AST_OE_WE_EXCLUSIVE: assert property (@(posedge ref_clk) disable iff (srst) // [R19]
		!(!card_out.oe_n && !card_out.we_n))
		else $error("oe and we low together");

	AST_MEM_READ_OE: assert property (@(posedge ref_clk) disable iff (srst) // [R1]
		(s_q.st == pcc_pkg::PCC_ST_STROBE && s_q.cur.op == pcc_pkg::PCC_OP_MEM_RD)
		|-> (!card_out.oe_n && card_out.we_n && card_out.reg_n))
		else $error("memory read strobe wrong");

	AST_DMA_WR_TC: assert property (@(posedge ref_clk) disable iff (srst) // [R2]
		(s_q.st == pcc_pkg::PCC_ST_STROBE && s_q.cur.op == pcc_pkg::PCC_OP_DMA_WR)
		|-> (card_out.oe_n == !s_q.cur.last) && !card_out.io_read_n && card_out.io_write_n)
		else $error("dma write strobes or terminal count wrong");

	AST_DMA_RD_TC: assert property (@(posedge ref_clk) disable iff (srst) // [R13]
		(s_q.st == pcc_pkg::PCC_ST_STROBE && s_q.cur.op == pcc_pkg::PCC_OP_DMA_RD)
		|-> (card_out.we_n == !s_q.cur.last) && !card_out.io_write_n && card_out.io_read_n)
		else $error("dma read strobes or terminal count wrong");

	AST_COMMON_REG_HIGH: assert property (@(posedge ref_clk) disable iff (srst) // [R6]
		(s_q.st != pcc_pkg::PCC_ST_IDLE && is_mem) |-> card_out.reg_n)
		else $error("reg low during common memory access");

	AST_DMA_ACKNOWLEDGE_REG_LOW: assert property (@(posedge ref_clk) disable iff (srst) // [R8]
		(s_q.st == pcc_pkg::PCC_ST_STROBE && !is_mem) |-> !card_out.reg_n)
		else $error("reg not low for attribute, io or dma");

	AST_WAIT_HOLDS: assert property (@(posedge ref_clk) disable iff (srst) // [R11]
		(s_q.st == pcc_pkg::PCC_ST_STROBE && s_q.cnt == '0 && !card_in.wait_n)
		|=> (s_q.st == pcc_pkg::PCC_ST_STROBE && !req_done))
		else $error("cycle ended while wait asserted");

	AST_MEM_WRITE_PULSE: assert property (@(posedge ref_clk) disable iff (srst) // [R12]
		$fell(card_out.we_n) && s_q.cur.op == pcc_pkg::PCC_OP_MEM_WR
		|-> (!card_out.we_n) [*3] ##1 1'b1)
		else $error("write enable pulse shorter than three cycles");

	AST_CARD_RESET: assert property (@(posedge ref_clk) disable iff (srst) // [R9]
		card_reset_req |=> (card_out.card_reset && !req_ready))
		else $error("card reset not forwarded");

	AST_LANES: assert property (@(posedge ref_clk) disable iff (srst) // [R18]
		(req_valid && req_ready && !card_reset_req)
		|=> (card_out.card_enable_even_n == !$past(req.lane_even))
		&& (card_out.card_enable_odd_n == !$past(req.lane_odd)))
		else $error("card enables do not follow byte lanes");

	AST_DONE_BOUND: assert property (@(posedge ref_clk) disable iff (srst) // [R11]
		(req_valid && req_ready && !card_reset_req && card_in.wait_n)
		##1 card_in.wait_n [*7] |-> ##[0:2] req_done)
		else $error("cycle without wait took too long");

	// full pin pattern per op, so a wrong decode cannot hide behind one strobe
	AST_MEM_WR_STROBE: assert property (@(posedge ref_clk) disable iff (srst) // [R12]
		(s_q.st == pcc_pkg::PCC_ST_STROBE && s_q.cur.op == pcc_pkg::PCC_OP_MEM_WR)
		|-> (!card_out.we_n && card_out.oe_n && card_out.reg_n
		&& card_out.io_read_n && card_out.io_write_n))
		else $error("memory write strobe wrong");

	AST_ATTR_RD_STROBE: assert property (@(posedge ref_clk) disable iff (srst) // [R7]
		(s_q.st == pcc_pkg::PCC_ST_STROBE && s_q.cur.op == pcc_pkg::PCC_OP_ATTR_RD)
		|-> (!card_out.oe_n && card_out.we_n && !card_out.reg_n
		&& card_out.io_read_n && card_out.io_write_n))
		else $error("attribute read strobe wrong");

	AST_ATTR_WR_STROBE: assert property (@(posedge ref_clk) disable iff (srst) // [R7]
		(s_q.st == pcc_pkg::PCC_ST_STROBE && s_q.cur.op == pcc_pkg::PCC_OP_ATTR_WR)
		|-> (!card_out.we_n && card_out.oe_n && !card_out.reg_n
		&& card_out.io_read_n && card_out.io_write_n))
		else $error("attribute write strobe wrong");

	AST_IO_RD_STROBE: assert property (@(posedge ref_clk) disable iff (srst) // [R7]
		(s_q.st == pcc_pkg::PCC_ST_STROBE && s_q.cur.op == pcc_pkg::PCC_OP_IO_RD)
		|-> (!card_out.io_read_n && card_out.io_write_n && !card_out.reg_n
		&& card_out.oe_n && card_out.we_n))
		else $error("io read strobe wrong");

	AST_IO_WR_STROBE: assert property (@(posedge ref_clk) disable iff (srst) // [R7]
		(s_q.st == pcc_pkg::PCC_ST_STROBE && s_q.cur.op == pcc_pkg::PCC_OP_IO_WR)
		|-> (!card_out.io_write_n && card_out.io_read_n && !card_out.reg_n
		&& card_out.oe_n && card_out.we_n))
		else $error("io write strobe wrong");

	// setup and hold keep every strobe off so selects settle around the pulse
	AST_STROBES_OFF_EDGES: assert property (@(posedge ref_clk) disable iff (srst) // [R19]
		(s_q.st == pcc_pkg::PCC_ST_SETUP || s_q.st == pcc_pkg::PCC_ST_HOLD)
		|-> (card_out.oe_n && card_out.we_n && card_out.io_read_n && card_out.io_write_n))
		else $error("strobe active outside strobe phase");

	AST_IDLE_QUIET: assert property (@(posedge ref_clk) disable iff (srst) // [R6]
		(s_q.st == pcc_pkg::PCC_ST_IDLE)
		|-> (card_out.oe_n && card_out.we_n && card_out.io_read_n && card_out.io_write_n
		&& card_out.reg_n && card_out.card_enable_even_n && card_out.card_enable_odd_n))
		else $error("card pins active while idle");

	AST_OE_MIN_WIDTH: assert property (@(posedge ref_clk) disable iff (srst) // [R1]
		$fell(card_out.oe_n) |-> (!card_out.oe_n) [*3])
		else $error("output enable pulse shorter than three cycles");

	AST_IOR_MIN_WIDTH: assert property (@(posedge ref_clk) disable iff (srst) // [R17]
		$fell(card_out.io_read_n) |-> (!card_out.io_read_n) [*3])
		else $error("io read pulse shorter than three cycles");

	// a lane change mid-cycle would tear a byte on the card
	AST_ENABLES_STEADY: assert property (@(posedge ref_clk) disable iff (srst) // [R18]
		(s_q.st != pcc_pkg::PCC_ST_IDLE && $past(s_q.st) != pcc_pkg::PCC_ST_IDLE)
		|-> ($stable(card_out.card_enable_even_n) && $stable(card_out.card_enable_odd_n)))
		else $error("card enables moved during a cycle");

	AST_CARD_RESET_OFF: assert property (@(posedge ref_clk) disable iff (srst) // [R9]
		!card_reset_req |=> !card_out.card_reset)
		else $error("card reset held without request");

	AST_HELD_OFF_IN_RESET: assert property (@(posedge ref_clk) disable iff (srst) // [R9]
		(s_q.st == pcc_pkg::PCC_ST_IDLE && card_reset_req) |=> (s_q.st == pcc_pkg::PCC_ST_IDLE))
		else $error("cycle started while card held in reset");

	AST_DONE_PULSE: assert property (@(posedge ref_clk) disable iff (srst) // [R11]
		req_done |=> !req_done)
		else $error("done longer than one cycle");

	AST_DONE_READY: assert property (@(posedge ref_clk) disable iff (srst) // [R9]
		req_done |-> (req_ready == !$past(card_reset_req)))
		else $error("ready wrong at end of cycle");

	COV_MEM_READ: cover property (@(posedge ref_clk) disable iff (srst)
		req_done && s_q.cur.op == pcc_pkg::PCC_OP_MEM_RD);

	COV_DMA_TC: cover property (@(posedge ref_clk) disable iff (srst)
		!card_out.oe_n && !card_out.io_read_n && !card_out.reg_n);

	COV_WAIT_STRETCH: cover property (@(posedge ref_clk) disable iff (srst)
		s_q.st == pcc_pkg::PCC_ST_STROBE && s_q.cnt == '0 && !card_in.wait_n [*3]);

	COV_ATTR_WRITE: cover property (@(posedge ref_clk) disable iff (srst)
		!card_out.we_n && !card_out.reg_n && s_q.cur.op == pcc_pkg::PCC_OP_ATTR_WR);

endmodule

`default_nettype wire

// *** design/pcc_defs.svh ***
// timing counts and pin encodings for the pc card control sequencer
// assumes ref_clk at 250 MHz; counts are in ref_clk cycles
`ifndef PCC_DEFS_SVH
`define PCC_DEFS_SVH

`define PCC_CLK_PERIOD_NS 4
// address and select setup ahead of the strobe, in ns
`define PCC_SETUP_NS 8
// least strobe width before wait is honoured, in ns
`define PCC_STROBE_NS 12
// select hold after the strobe, in ns
`define PCC_HOLD_NS 4
`define PCC_SETUP_CYC ((`PCC_SETUP_NS + `PCC_CLK_PERIOD_NS - 1) / `PCC_CLK_PERIOD_NS)
`define PCC_STROBE_CYC ((`PCC_STROBE_NS + `PCC_CLK_PERIOD_NS - 1) / `PCC_CLK_PERIOD_NS)
`define PCC_HOLD_CYC ((`PCC_HOLD_NS + `PCC_CLK_PERIOD_NS - 1) / `PCC_CLK_PERIOD_NS)
`define PCC_CNT_W 4
// card strobes idle high
`define PCC_PIN_IDLE 1'h1
`define PCC_PIN_ACTIVE 1'h0
// card reset asserted while the controller itself is in reset
`define PCC_CARD_RESET_INIT 1'h1
// voltage sense lines: the controller never drives them
`define PCC_VS_DRIVE 2'h0

`endif

// *** design/pcc_pkg.sv ***
// types shared by the pc card control sequencer and its sense stage
// assumes pcc_defs.svh is on the include path
`default_nettype none

package pcc_pkg;

	typedef enum logic [2:0] {
		PCC_OP_MEM_RD = 3'h0,
		PCC_OP_MEM_WR = 3'h1,
		PCC_OP_ATTR_RD = 3'h2,
		PCC_OP_ATTR_WR = 3'h3,
		PCC_OP_IO_RD = 3'h4,
		PCC_OP_IO_WR = 3'h5,
		PCC_OP_DMA_RD = 3'h6,
		PCC_OP_DMA_WR = 3'h7
	} pcc_op_t;

	typedef enum logic [3:0] {
		PCC_ST_IDLE = 4'h1,
		PCC_ST_SETUP = 4'h2,
		PCC_ST_STROBE = 4'h4,
		PCC_ST_HOLD = 4'h8
	} pcc_state_t;

	typedef enum logic [1:0] {
		PCC_VOLT_5V = 2'h0,
		PCC_VOLT_3V = 2'h1,
		PCC_VOLT_LOW = 2'h2,
		PCC_VOLT_NONE = 2'h3
	} pcc_volt_t;

	typedef struct packed {
		pcc_op_t op;
		logic last;
		logic lane_even;
		logic lane_odd;
	} pcc_req_t;

	typedef struct packed {
		logic oe_n;
		logic we_n;
		logic reg_n;
		logic io_read_n;
		logic io_write_n;
		logic card_enable_even_n;
		logic card_enable_odd_n;
		logic card_reset;
		logic [1:0] vs_out;
		logic [1:0] vs_oe;
	} pcc_card_out_t;

	typedef struct packed {
		logic ready_irq;
		logic wait_n;
		logic wp;
		logic voltage_sense_first;
		logic voltage_sense_second;
	} pcc_card_in_t;

	typedef struct packed {
		logic card_ready;
		logic interrupt_request;
		logic write_protect;
		logic io_port_sixteen_bit;
		logic dma_request;
		pcc_volt_t volt;
	} pcc_status_t;

endpackage

`default_nettype wire

// *** design/pcc_sense.sv ***
// sense stage: registers and decodes the shared card status inputs
// assumes card inputs already synchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none

module pcc_sense (
	input wire logic ref_clk,
	input wire logic srst,
	input wire pcc_pkg::pcc_card_in_t card_in,
	input wire logic mem_only,
	input wire logic dma_req_en,
	output pcc_pkg::pcc_status_t status
);

	pcc_pkg::pcc_status_t st_d;
	pcc_pkg::pcc_status_t st_q;

	always_comb begin
		st_d = st_q;
		// one pin, two meanings; the configuration picks which
		st_d.card_ready = mem_only & card_in.ready_irq; // [R4]
		st_d.interrupt_request = ~mem_only & ~card_in.ready_irq;
		st_d.write_protect = mem_only & ~dma_req_en & card_in.wp;
		st_d.io_port_sixteen_bit = ~mem_only & ~dma_req_en & ~card_in.wp;
		st_d.dma_request = dma_req_en & card_in.wp; // [R16]
		// only the pair means anything, never one line alone
		case ({card_in.voltage_sense_second, card_in.voltage_sense_first}) // [R10]
			2'h3: st_d.volt = pcc_pkg::PCC_VOLT_5V;
			2'h2: st_d.volt = pcc_pkg::PCC_VOLT_3V;
			2'h1: st_d.volt = pcc_pkg::PCC_VOLT_LOW;
			default: st_d.volt = pcc_pkg::PCC_VOLT_NONE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign status = st_q;

	AST_READY_ONLY_MEM: assert property (@(posedge ref_clk) disable iff (srst) // [R4]
		!mem_only |=> !status.card_ready)
		else $error("ready reported outside memory-only mode");

	AST_VOLT_PAIR: assert property (@(posedge ref_clk) disable iff (srst) // [R10]
		(card_in.voltage_sense_first && !card_in.voltage_sense_second)
		|=> status.volt == pcc_pkg::PCC_VOLT_LOW)
		else $error("voltage code not taken from both sense lines");

	AST_DMA_REQ: assert property (@(posedge ref_clk) disable iff (srst) // [R16]
		(dma_req_en && card_in.wp) |=> (status.dma_request && !status.write_protect))
		else $error("dma request on write protect not accepted");

endmodule

`default_nettype wire

// *** test/pcc_card_model.sv ***
// behavioural 16-bit card on the far side of the pc card control sequencer
// assumes card strobes are registered on ref_clk and the bench sets the card's mood
`timescale 1ns/100ps
`default_nettype none

module pcc_card_model (
	input wire logic ref_clk,
	input wire pcc_pkg::pcc_card_out_t card_out,
	input wire logic mem_card,
	input wire logic dma_card,
	input wire logic busy,
	input wire logic need_irq,
	input wire logic wp_switch,
	input wire logic port16,
	input wire logic dma_rq,
	input wire logic [1:0] vs_code,
	input wire logic [3:0] wait_len,
	output pcc_pkg::pcc_card_in_t card_in
);
	logic strobe;
	logic [3:0] strobe_cnt_q;

	assign strobe = !(card_out.oe_n & card_out.we_n & card_out.io_read_n & card_out.io_write_n);

	always_ff @(posedge ref_clk) begin
		if (!strobe)
			strobe_cnt_q <= 4'h0;
		else if (strobe_cnt_q != 4'hf)
			strobe_cnt_q <= strobe_cnt_q + 4'h1;
	end

	// wait pulled up outside strobes; held low for wait_len strobe cycles
	assign card_in.wait_n = !(strobe && strobe_cnt_q < wait_len);
	assign card_in.ready_irq = mem_card ? !busy : !need_irq;
	// one pin, three meanings, picked by how the card is configured
	assign card_in.wp = dma_card ? dma_rq : (mem_card ? wp_switch : !port16);
	assign card_in.voltage_sense_first = vs_code[0];
	assign card_in.voltage_sense_second = vs_code[1];
endmodule

`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for the pc card control sequencer
// assumes the card model answers strobes and status pins as configured here
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	logic ref_clk, srst, req_valid, mem_only, dma_req_en, card_reset_req, req_ready, req_done;
	logic busy, need_irq, wp_switch, port16, dma_rq;
	logic [1:0] vs_code;
	logic [3:0] wait_len;
	pcc_pkg::pcc_req_t req;
	pcc_pkg::pcc_card_in_t card_in;
	pcc_pkg::pcc_card_out_t card_out;
	pcc_pkg::pcc_status_t status;
	int err_count, checks_done;

	pcc_ctrl u_pcc_ctrl (.ref_clk(ref_clk), .srst(srst), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .req_done(req_done), .mem_only(mem_only),
		.dma_req_en(dma_req_en), .card_reset_req(card_reset_req), .card_in(card_in),
		.card_out(card_out), .status(status));
	pcc_card_model u_pcc_card_model (.ref_clk(ref_clk), .card_out(card_out),
		.mem_card(mem_only), .dma_card(dma_req_en), .busy(busy), .need_irq(need_irq),
		.wp_switch(wp_switch), .port16(port16), .dma_rq(dma_rq), .vs_code(vs_code),
		.wait_len(wait_len), .card_in(card_in));

	initial begin
		ref_clk = 1'h0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		if (err_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic settle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// one host request; counts strobe cycles while the cycle runs
	task automatic run_op(input logic [2:0] op, input logic last, input logic le,
		input logic lo, input logic [3:0] wl);
		int oe, we, ior, iow, rg, ce_e, ce_o, both, n;
		logic [4:0] ex;
		oe = 0; we = 0; ior = 0; iow = 0; rg = 0; ce_e = 0; ce_o = 0; both = 0; n = 0;
		case (op)
			3'h0: ex = 5'h10;
			3'h1: ex = 5'h08;
			3'h2: ex = 5'h11;
			3'h3: ex = 5'h09;
			3'h4: ex = 5'h05;
			3'h5: ex = 5'h03;
			3'h6: ex = {1'h0, last, 3'h3};
			default: ex = {last, 4'h5};
		endcase
		@(posedge ref_clk);
		wait_len <= wl;
		req_valid <= 1'h1;
		req <= '{op: pcc_pkg::pcc_op_t'(op), last: last, lane_even: le, lane_odd: lo};
		do begin
			@(negedge ref_clk);
			n++;
		end while (req_ready !== 1'h1 && n < 50);
		@(posedge ref_clk);
		req_valid <= 1'h0;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
			oe += int'(card_out.oe_n === 1'h0);
			we += int'(card_out.we_n === 1'h0);
			ior += int'(card_out.io_read_n === 1'h0);
			iow += int'(card_out.io_write_n === 1'h0);
			rg += int'(card_out.reg_n === 1'h0);
			ce_e += int'(card_out.card_enable_even_n === 1'h0);
			ce_o += int'(card_out.card_enable_odd_n === 1'h0);
			both += int'(card_out.oe_n === 1'h0 && card_out.we_n === 1'h0);
		end while (req_done !== 1'h1 && n < 60);
		check(32'(n < 60), 32'h1);
		if (wl == 4'h0) begin
			check({oe[7:0], we[7:0], ior[7:0], iow[7:0]},
				{ex[4] ? 8'h3 : 8'h0, ex[3] ? 8'h3 : 8'h0,
				ex[2] ? 8'h3 : 8'h0, ex[1] ? 8'h3 : 8'h0});
		end else begin
			// wait must stretch the strobe, but only by a bounded amount
			check(32'(oe >= int'(wl) && oe <= int'(wl) + 3), 32'h1);
		end
		check(32'(rg != 0), 32'(ex[0]));
		check({31'h0, ce_e != 0}, {31'h0, le});
		check({31'h0, ce_o != 0}, {31'h0, lo});
		check(32'(both), 32'h0);
	endtask

	task automatic ops_all();
		logic [3:0] i;
		for (i = 4'h0; i < 4'ha; i++)
			run_op(i < 4'h8 ? i[2:0] : i[2:0] + 3'h6, i[3], ~i[0] | i[3], i[0] | i[3], 4'h0);
		run_op(3'h0, 1'h0, 1'h1, 1'h1, 4'h6);
	endtask

	task automatic status_all();
		logic [2:0] v;
		@(posedge ref_clk);
		mem_only <= 1'h1;
		busy <= 1'h1;
		wp_switch <= 1'h1;
		settle(3);
		check(32'(status.card_ready), 32'h0);
		check(32'(status.write_protect), 32'h1);
		@(posedge ref_clk);
		busy <= 1'h0;
		settle(3);
		check(32'(status.card_ready), 32'h1);
		@(posedge ref_clk);
		mem_only <= 1'h0;
		need_irq <= 1'h1;
		port16 <= 1'h1;
		settle(3);
		check(32'(status.interrupt_request), 32'h1);
		check(32'(status.io_port_sixteen_bit), 32'h1);
		@(posedge ref_clk);
		need_irq <= 1'h0;
		settle(3);
		check({status.card_ready, status.interrupt_request}, 32'h0);
		@(posedge ref_clk);
		dma_req_en <= 1'h1;
		dma_rq <= 1'h1;
		settle(3);
		check(32'(status.dma_request), 32'h1);
		for (v = 3'h0; v < 3'h4; v++) begin
			@(posedge ref_clk);
			vs_code <= v[1:0];
			settle(3);
			check(32'(status.volt), {30'h0, ~v[1:0]});
		end
		@(posedge ref_clk);
		dma_req_en <= 1'h0;
		mem_only <= 1'h1;
	endtask

	// card reset also holds off the request port
	task automatic card_reset_case();
		@(posedge ref_clk);
		card_reset_req <= 1'h1;
		settle(3);
		check({card_out.card_reset, req_ready}, 32'h2);
		@(posedge ref_clk);
		card_reset_req <= 1'h0;
		settle(3);
		check({card_out.card_reset, req_ready}, 32'h1);
	endtask

	initial begin
		srst = 1'h1;
		req_valid = 1'h0;
		req = '0;
		mem_only = 1'h1;
		dma_req_en = 1'h0;
		card_reset_req = 1'h0;
		busy = 1'h0;
		need_irq = 1'h0;
		wp_switch = 1'h0;
		port16 = 1'h0;
		dma_rq = 1'h0;
		vs_code = 2'h3;
		wait_len = 4'h0;
		err_count = 0;
		checks_done = 0;
		repeat (3) @(posedge ref_clk);
		settle(1);
		check({card_out.card_reset, card_out.oe_n, card_out.we_n}, 32'h7);
		check({card_out.vs_out, card_out.vs_oe}, 32'h0);
		@(posedge ref_clk);
		srst <= 1'h0;
		settle(3);
		ops_all();
		status_all();
		card_reset_case();
		run_op(3'h1, 1'h0, 1'h1, 1'h0, 4'h0);
		end_of_test();
	end

	// whole run is under two hundred cycles; this leaves a wide margin
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		end_of_test();
	end
endmodule

`default_nettype wire
